// ---- pacc_pkg.sv ----
// Constants shared by the pulse accumulator block: register offsets,
// field positions and reset values.
// Assumes a 32-bit APB bus with one register per aligned word.
package pacc_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] PACC_OFS_VAL4  = 8'h00;  // Channel 4 value register.
  localparam logic [7:0] PACC_OFS_VAL5  = 8'h04;  // Channel 5 value register.
  localparam logic [7:0] PACC_OFS_VAL6  = 8'h08;  // Channel 6 value register.
  localparam logic [7:0] PACC_OFS_VAL7  = 8'h0C;  // Channel 7 value register.
  localparam logic [7:0] PACC_OFS_CTRL  = 8'h10;  // Accumulator control register.
  localparam logic [7:0] PACC_OFS_FLAGS = 8'h14;  // Accumulator flag register.
  localparam logic [7:0] PACC_OFS_COUNT = 8'h18;  // Accumulator count register.
  localparam logic [7:0] PACC_OFS_CFG   = 8'h1C;  // Timer-side configuration register.

  // Accumulator control field positions.
  localparam int PACC_CTRL_EN_BIT   = 6;  // Accumulator enable.
  localparam int PACC_CTRL_MODE_BIT = 5;  // Mode select, 1 is gated.
  localparam int PACC_CTRL_EDGE_BIT = 4;  // Edge or level select.
  localparam int PACC_CTRL_CLK_LSB  = 2;  // Two-bit counter clock select.
  localparam int PACC_CTRL_OVI_BIT  = 1;  // Overflow interrupt enable.
  localparam int PACC_CTRL_II_BIT   = 0;  // Input interrupt enable.

  // Flag register field positions.
  localparam int PACC_FLG_OVF_BIT = 1;  // Overflow flag.
  localparam int PACC_FLG_IF_BIT  = 0;  // Input edge flag.

  // Configuration register field positions.
  localparam int PACC_CFG_SEL_LSB  = 0;  // Four capture/compare select bits.
  localparam int PACC_CFG_TON_BIT  = 4;  // Timer on.
  localparam int PACC_CFG_FFCA_BIT = 5;  // Fast flag clear.

  // Counter clock select encodings.
  localparam logic [1:0] PACC_CLK_PRESC  = 2'h0;  // Prescaler clock.
  localparam logic [1:0] PACC_CLK_ACC    = 2'h1;  // Accumulator tick.
  localparam logic [1:0] PACC_CLK_DIV256 = 2'h2;  // Accumulator tick / 256.
  localparam logic [1:0] PACC_CLK_DIV64K = 2'h3;  // Accumulator tick / 65536.

  // Reset values and count limits.
  localparam logic [15:0] PACC_VAL_RST   = 16'h0000;  // Channel value reset.
  localparam logic [7:0]  PACC_CTRL_RST  = 8'h00;     // Control reset.
  localparam logic [1:0]  PACC_FLAGS_RST = 2'h0;      // Flags reset.
  localparam logic [15:0] PACC_COUNT_RST = 16'h0000;  // Count reset.
  localparam logic [5:0]  PACC_CFG_RST   = 6'h00;     // Configuration reset.
  localparam logic [15:0] PACC_COUNT_MAX = 16'hFFFF;  // Count rollover point.
  localparam logic [7:0]  PACC_LOW_MAX   = 8'hFF;     // Low byte rollover (/256).

  // APB answer state; one wait state per transfer.
  typedef enum logic [0:0] {
    PACC_ST_IDLE = 1'b0,  // Waiting for an access phase.
    PACC_ST_ACK  = 1'b1   // Pready is high this cycle.
  } pacc_state_t;

endpackage : pacc_pkg

// ---- pacc_pulse_accumulator.sv ----
// Pulse accumulator with channel 4..7 capture/compare value registers,
// reached over APB.
// Assumes the timer prescaler, its divide-by-64 tick and the free-running
// counter come from logic on the same clock; pins are asynchronous.
//
// Summary of operation
// - Capture counter on edge, or compare stored value.
// - Value writes only land in compare mode.
// - Channel value registers reset to zero.
// - Accumulator enable independent of timer enable.
// - Accumulator input is channel 7 pin.
// - Mode bit honoured only while enabled.
// - Event mode edge bit selects falling/rising.
// - Gated mode level gates divide-by-64 tick.
// - Gated tick absent while timer is off.
// - Clock select picks timer counter clock.
// - Disabled accumulator forces prescaler clock.
// - Clock select change takes effect immediately.
// - Interrupt requests from flags and enables.
// - Overflow flag on rollover, write-one clears.
// - Input flag on active edge, write-one clears.
// - Fast clear: count access clears both flags.
// - Event mode: each active edge counts one.
// - Gated mode: one count per gated tick.
//
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/100ps
module pacc_pulse_accumulator import pacc_pkg::*; (
  input  wire logic        clk,              // 125 MHz bus clock.
  input  wire logic        sys_rst,          // Synchronous reset, active high.
  input  wire logic        psel,             // APB select.
  input  wire logic        penable,          // APB enable.
  input  wire logic        pwrite,           // APB direction, high for write.
  input  wire logic [7:0]  paddr,            // APB byte address.
  input  wire logic [31:0] pwdata,           // APB write data.
  output logic      [31:0] prdata,           // APB read data.
  output logic             pready,           // APB ready.
  output logic             pslverr,          // APB error on unmapped address.
  input  wire logic        sharedChannelPin, // Channel 7 pin, accumulator input.
  input  wire logic [2:0]  chanPin,          // Channel 4..6 pins.
  input  wire logic [15:0] timerCount,       // Free-running timer counter.
  input  wire logic        prescalerTick,    // Timer prescaler clock pulse.
  input  wire logic        div64Tick,        // Prescaler divide-by-64 pulse.
  output logic             counterTick,      // Selected timer counter clock pulse.
  output logic      [3:0]  compareMatch,     // Compare match per channel 4..7.
  output logic             overflowIrq,      // Overflow interrupt request.
  output logic             inputIrq          // Input edge interrupt request.
);

  // The whole state of the block in one packed struct.
  typedef struct packed {
    pacc_state_t      st;        // APB answer state.
    logic [31:0]      rdata;     // Read data held for the answer.
    logic             ready;     // Registered pready.
    logic             err;       // Registered pslverr.
    logic [3:0]       sync1;     // First synchroniser stage.
    logic [3:0]       sync2;     // Second synchroniser stage.
    logic [3:0]       prev;      // Last synchronised level, for edges.
    logic [3:0][15:0] val;       // Channel 4..7 value registers.
    logic [7:0]       ctrl;      // Accumulator control register.
    logic [1:0]       flags;     // Overflow and input edge flags.
    logic [15:0]      count;     // Accumulator count.
    logic [5:0]       cfg;       // Select bits, timer on, fast clear.
    logic             cntTick;   // Registered counter clock pulse.
    logic [3:0]       match;     // Registered compare matches.
    logic             ovIrq;     // Registered overflow request.
    logic             inIrq;     // Registered input request.
  } pacc_regs_t;

  pacc_regs_t stat_r;  // Current state.
  pacc_regs_t stat_nxt;  // Next state.

  // Decoded control and helper terms.
  logic        accOn;     // Accumulator enabled.
  logic        gated;     // Gated time accumulation selected.
  logic        edgeSel;   // Edge or level select bit.
  logic [1:0]  clkSel;    // Counter clock select.
  logic [3:0]  ccSel;     // Per-channel compare select.
  logic        timerOn;   // Timer enable.
  logic        fastClr;   // Fast flag clear.
  logic        pinNow;    // Synchronised shared pin.
  logic        pinRise;   // Rising edge on shared pin.
  logic        pinFall;   // Falling edge on shared pin.
  logic        actEdge;   // Active edge for counting or flag.
  logic        gateOpen;  // Gate level active in gated mode.
  logic        accTick;   // Accumulator increments this cycle.
  logic        apbSetup;  // Access phase seen while idle.
  logic        apbDone;   // Access completes at this edge.
  logic        wrDone;    // Write takes effect at this edge.
  logic        mapped;    // Address hits a register.
  logic        cntAccess; // Count register accessed at this edge.

  assign accOn    = stat_r.ctrl[PACC_CTRL_EN_BIT];
  assign gated    = stat_r.ctrl[PACC_CTRL_MODE_BIT];
  assign edgeSel  = stat_r.ctrl[PACC_CTRL_EDGE_BIT];
  assign clkSel   = stat_r.ctrl[PACC_CTRL_CLK_LSB +: 2];
  assign ccSel    = stat_r.cfg[PACC_CFG_SEL_LSB +: 4];
  assign timerOn  = stat_r.cfg[PACC_CFG_TON_BIT];
  assign fastClr  = stat_r.cfg[PACC_CFG_FFCA_BIT];
  // Channel 7 sits in bit 3; the accumulator reads the same synchronised level.
  assign pinNow   = stat_r.sync2[3];
  assign pinRise  = pinNow & ~stat_r.prev[3];
  assign pinFall  = ~pinNow & stat_r.prev[3];
  // Edge bit 0 means falling edges count, and in gated mode the high gate
  // ends on a falling edge, so one term serves both modes.
  assign actEdge  = edgeSel ? pinRise : pinFall;
  assign gateOpen = edgeSel ? ~pinNow : pinNow;
  // Mode is only looked at behind the enable; a disabled accumulator holds.
  // The divide-by-64 tick is gated by timer on because the prescaler stops.
  assign accTick  = accOn & (gated ? (gateOpen & div64Tick & timerOn)
                                   : actEdge);
  assign apbSetup = psel & penable & (stat_r.st == PACC_ST_IDLE);
  assign apbDone  = psel & penable & stat_r.ready;
  assign wrDone   = apbDone & pwrite & ~stat_r.err;
  assign mapped   = (paddr[1:0] == 2'h0) && (paddr <= PACC_OFS_CFG);
  assign cntAccess = apbDone & (paddr == PACC_OFS_COUNT);

  // Next-state logic: synchroniser, APB slave, capture, accumulator, flags.
  always_comb begin
    logic [15:0] cntNext;  // Count after increment.
    logic [1:0]  setF;     // Flags set by hardware this cycle.
    logic [1:0]  clrF;     // Flags cleared by software this cycle.
    logic        derived;  // Selected counter clock before forcing.
    cntNext  = stat_r.count + 16'h0001;
    setF     = 2'h0;
    clrF     = 2'h0;
    derived  = 1'b0;
    stat_nxt = stat_r;

    // Two-stage synchroniser; only the second stage feeds edge logic.
    stat_nxt.sync1 = {sharedChannelPin, chanPin};
    stat_nxt.sync2 = stat_r.sync1;
    stat_nxt.prev  = stat_r.sync2;

    // APB answer: one wait state, then pready high for one cycle.
    stat_nxt.ready = 1'b0;
    stat_nxt.err   = 1'b0;
    stat_nxt.st    = PACC_ST_IDLE;
    if (apbSetup) begin
      stat_nxt.st    = PACC_ST_ACK;
      stat_nxt.ready = 1'b1;
      stat_nxt.err   = ~mapped;
      stat_nxt.rdata = 32'h0000_0000;
      case (paddr)
        PACC_OFS_VAL4:  stat_nxt.rdata[15:0] = stat_r.val[0];
        PACC_OFS_VAL5:  stat_nxt.rdata[15:0] = stat_r.val[1];
        PACC_OFS_VAL6:  stat_nxt.rdata[15:0] = stat_r.val[2];
        PACC_OFS_VAL7:  stat_nxt.rdata[15:0] = stat_r.val[3];
        PACC_OFS_CTRL:  stat_nxt.rdata[7:0]  = stat_r.ctrl;
        PACC_OFS_FLAGS: stat_nxt.rdata[1:0]  = stat_r.flags;
        PACC_OFS_COUNT: stat_nxt.rdata[15:0] = stat_r.count;
        PACC_OFS_CFG:   stat_nxt.rdata[5:0]  = stat_r.cfg;
        default:        stat_nxt.rdata       = 32'h0000_0000;
      endcase
    end

    // Capture on a rising synchronised edge for channels in capture mode.
    for (int i = 0; i < 4; i++) begin
      if (!ccSel[i] && stat_r.sync2[i] && !stat_r.prev[i]) begin
        stat_nxt.val[i] = timerCount;
      end
    end

    // Accumulator count; a software write overrides a coincident increment.
    if (accTick) begin
      stat_nxt.count = cntNext;
      setF[PACC_FLG_OVF_BIT] = (stat_r.count == PACC_COUNT_MAX);
    end
    if (accOn && actEdge) begin
      setF[PACC_FLG_IF_BIT] = 1'b1;
    end

    // Register writes take effect at the edge that sees pready high.
    if (wrDone) begin
      case (paddr)
        PACC_OFS_VAL4, PACC_OFS_VAL5, PACC_OFS_VAL6, PACC_OFS_VAL7: begin
          // Writes in capture mode are dropped.
          if (ccSel[paddr[3:2]]) begin
            stat_nxt.val[paddr[3:2]] = pwdata[15:0];
          end
        end
        PACC_OFS_CTRL:  stat_nxt.ctrl = pwdata[7:0];
        PACC_OFS_FLAGS: clrF = pwdata[1:0];
        PACC_OFS_COUNT: stat_nxt.count = pwdata[15:0];
        PACC_OFS_CFG:   stat_nxt.cfg = pwdata[5:0];
        default:        stat_nxt.cfg = stat_r.cfg;
      endcase
    end
    // Any count access clears both flags when fast clear is on.
    if (cntAccess && fastClr) begin
      clrF = 2'h3;
    end
    // A hardware set in the clearing cycle wins.
    stat_nxt.flags = (stat_r.flags & ~clrF) | setF;

    // Counter clock mux; selection is combinational so a new select is
    // used from the first cycle after the write, with no resynchronising.
    case (clkSel)
      PACC_CLK_PRESC:  derived = prescalerTick;
      PACC_CLK_ACC:    derived = accTick;
      PACC_CLK_DIV256: derived = accTick & (stat_r.count[7:0] == PACC_LOW_MAX);
      PACC_CLK_DIV64K: derived = accTick & (stat_r.count == PACC_COUNT_MAX);
      default:         derived = prescalerTick;
    endcase
    stat_nxt.cntTick = accOn ? derived : prescalerTick;

    // Compare matches for channels in compare mode.
    for (int i = 0; i < 4; i++) begin
      stat_nxt.match[i] = ccSel[i] & (timerCount == stat_r.val[i]);
    end

    // Interrupt requests follow the updated flags and enables.
    stat_nxt.ovIrq = stat_nxt.flags[PACC_FLG_OVF_BIT] & stat_nxt.ctrl[PACC_CTRL_OVI_BIT];
    stat_nxt.inIrq = stat_nxt.flags[PACC_FLG_IF_BIT] & stat_nxt.ctrl[PACC_CTRL_II_BIT];
  end

  // State register with synchronous reset.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stat_r         <= '0;
      stat_r.st      <= PACC_ST_IDLE;
      stat_r.val     <= {4{PACC_VAL_RST}};
      stat_r.ctrl    <= PACC_CTRL_RST;
      stat_r.flags   <= PACC_FLAGS_RST;
      stat_r.count   <= PACC_COUNT_RST;
      stat_r.cfg     <= PACC_CFG_RST;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  // All outputs come straight from the state flip-flops.
  assign prdata       = stat_r.rdata;
  assign pready       = stat_r.ready;
  assign pslverr      = stat_r.err;
  assign counterTick  = stat_r.cntTick;
  assign compareMatch = stat_r.match;
  assign overflowIrq  = stat_r.ovIrq;
  assign inputIrq     = stat_r.inIrq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Capture loads the free-running counter one edge after a synced rise.
  property p_capture;
    (!ccSel[3] && pinRise) |=> (stat_r.val[3] == $past(timerCount));
  endproperty
  a_capture: assert property (p_capture) else $error("capture value wrong");

  // A write in capture mode leaves the value unchanged.
  property p_cap_wr_ignored;
    (wrDone && paddr == PACC_OFS_VAL4 && !ccSel[0] && !(stat_r.sync2[0] && !stat_r.prev[0]))
      |=> $stable(stat_r.val[0]);
  endproperty
  a_cap_wr_ignored: assert property (p_cap_wr_ignored) else $error("capture write landed");

  // Disabled accumulator holds its count unless software writes it.
  property p_hold_disabled;
    (!accOn && !(wrDone && paddr == PACC_OFS_COUNT)) |=> $stable(stat_r.count);
  endproperty
  a_hold_disabled: assert property (p_hold_disabled) else $error("count moved");

  // Event mode counts each active edge by exactly one.
  property p_event_count;
    (accOn && !gated && actEdge && !wrDone) |=> (stat_r.count == $past(stat_r.count) + 16'h0001);
  endproperty
  a_event_count: assert property (p_event_count) else $error("event not counted");

  // Gated mode never counts while the timer is off.
  property p_gated_timer_off;
    (accOn && gated && !timerOn && !wrDone) |=> $stable(stat_r.count);
  endproperty
  a_gated_timer_off: assert property (p_gated_timer_off) else $error("tick while off");

  // Rollover sets the overflow flag.
  property p_overflow;
    (accTick && stat_r.count == PACC_COUNT_MAX) |=> stat_r.flags[PACC_FLG_OVF_BIT];
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow flag missed");

  // Disabled accumulator passes the prescaler tick one cycle later.
  property p_presc_forced;
    !accOn |=> (counterTick == $past(prescalerTick));
  endproperty
  a_presc_forced: assert property (p_presc_forced) else $error("wrong counter clock");

  // Fast clear with no new event empties the flags.
  property p_fast_clear;
    (cntAccess && fastClr && !accTick && !(accOn && actEdge)) |=> (stat_r.flags == 2'h0);
  endproperty
  a_fast_clear: assert property (p_fast_clear) else $error("fast clear failed");

  // Overflow request tracks flag and enable.
  property p_ov_irq;
    ##1 (overflowIrq == (stat_r.flags[PACC_FLG_OVF_BIT] & stat_r.ctrl[PACC_CTRL_OVI_BIT]));
  endproperty
  a_ov_irq: assert property (p_ov_irq) else $error("overflow request wrong");

  // Pready answers one cycle after an access phase, for one cycle.
  property p_apb_answer;
    apbSetup |=> pready ##1 !pready;
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("pready timing wrong");

  c_overflow: cover property (accTick && stat_r.count == PACC_COUNT_MAX);
  c_gated:    cover property (accOn && gated && accTick);
  c_capture:  cover property (!ccSel[3] && pinRise);
  c_div256:   cover property (accOn && clkSel == PACC_CLK_DIV256 && counterTick);

endmodule : pacc_pulse_accumulator

// ---- pacc_pulse_src.sv ----
// Behavioural pulse source that stands on the shared channel 7 pin.
// Assumes the bench calls its tasks right after a rising edge of clk.
`timescale 1ns/100ps
module pacc_pulse_src (
  input  wire logic clk,    // Bus clock.
  output logic      pinOut  // Drives the shared channel pin.
);
  // The pin idles low, so every pulse gives one rising and one falling edge.
  initial pinOut = 1'b0;

  // Each phase lasts four clocks, which is safely above the two-clock minimum width.
  task automatic pulses(input int n);
    for (int i = 0; i < n; i++) begin
      pinOut <= 1'b1;
      repeat (4) @(posedge clk);
      pinOut <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask : pulses

  // Holds a level long enough for the receiver's synchroniser to settle.
  task automatic level(input logic lvl);
    pinOut <= lvl;
    repeat (6) @(posedge clk);
  endtask : level
endmodule : pacc_pulse_src

// ---- tb_top.sv ----
// Self-checking bench for the pulse accumulator and channel value registers.
// Assumes the APB slave answers with pready and the pin source model above.
`timescale 1ns/100ps
module tb_top import pacc_pkg::*; ;
  logic        clk;            // Bus clock, 8 ns period.
  logic        sysRst;         // Synchronous reset, active high.
  logic        psel;           // APB select.
  logic        penable;        // APB enable.
  logic        pwrite;         // APB direction.
  logic [7:0]  paddr;          // APB address.
  logic [31:0] pwdata;         // APB write data.
  logic [31:0] prdata;         // APB read data.
  logic        pready;         // APB ready.
  logic        pslverr;        // APB error.
  logic        pin;            // Shared channel pin from the source model.
  logic [2:0]  chanPin;        // Channel 4..6 pins.
  logic [15:0] timerCount;     // Free-running counter stand-in.
  logic        prescalerTick;  // Prescaler pulse.
  logic        div64Tick;      // Divide-by-64 pulse.
  logic        counterTick;    // Selected counter clock.
  logic [3:0]  compareMatch;   // Compare matches.
  logic        overflowIrq;    // Overflow request.
  logic        inputIrq;       // Input request.
  int          miscompares;    // Mismatches seen.
  int          nTests;         // Comparisons made.
  int          ctN;            // Counter ticks seen so far.
  int          c0;             // Tick count at the start of a case.
  logic [7:0]  ctlTab [5] = '{8'h40, 8'h44, 8'h48, 8'h4C, 8'h04};  // Control per case.
  logic [15:0] stTab  [5] = '{16'h0000, 16'h0000, 16'h00FE, 16'hFFFE, 16'h0000};  // Start counts.
  int          pTab   [5] = '{2, 2, 3, 3, 2};  // Pin pulses per case.
  int          expTab [5] = '{3, 2, 1, 1, 3};  // Expected counter ticks.

  pacc_pulse_accumulator dut (
    .clk(clk), .sys_rst(sysRst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sharedChannelPin(pin), .chanPin(chanPin), .timerCount(timerCount),
    .prescalerTick(prescalerTick), .div64Tick(div64Tick), .counterTick(counterTick),
    .compareMatch(compareMatch), .overflowIrq(overflowIrq), .inputIrq(inputIrq));
  pacc_pulse_src src (.clk(clk), .pinOut(pin));

  // The clock toggles every half period.
  always #4 clk = ~clk;

  // Counts counter clock pulses; sampled before the edge's own updates land.
  always @(posedge clk) begin
    if (counterTick === 1'b1) ctN++;
  end

  // Compares one value and reports a mismatch at once.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    nTests++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One APB transfer; the request holds until pready is sampled high at an edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    int k;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    q = prdata;
    err = pslverr;
    if (k >= 20) begin
      miscompares++;
      $display("[FAIL] pready expected 1 seen 0");
    end
    psel <= 1'b0;
    penable <= 1'b0;
    // An idle cycle keeps two transfers from driving psel twice in one time step.
    @(posedge clk);
  endtask : apb

  // Whole-word write, so the high and low bytes always move together.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  // Word read compared with an expected value.
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    chk(what, exp, q);
  endtask : rd_chk

  // One-cycle pulses on the prescaler or the divide-by-64 input.
  task automatic tick(input logic useDiv, input int n);
    repeat (n) begin
      if (useDiv) div64Tick <= 1'b1;
      else prescalerTick <= 1'b1;
      @(posedge clk);
      div64Tick <= 1'b0;
      prescalerTick <= 1'b0;
      @(posedge clk);
    end
  endtask : tick

  // Prints the counts and the verdict, then stops.
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  // A hang is cut short well beyond the several hundred cycles the tests need.
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    $display("[FAIL] watchdog expected finish seen timeout");
    wrap_up();
  end

  // Main sequence.
  initial begin
    logic [31:0] q;
    logic        e;
    clk = 1'b0; sysRst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; chanPin = 3'h0; timerCount = 16'h0;
    prescalerTick = 1'b0; div64Tick = 1'b0; miscompares = 0; nTests = 0; ctN = 0;
    repeat (10) @(posedge clk);
    sysRst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 8; i++) rd_chk("reset value", 8'(4 * i), 32'h0);
    apb(1'b0, 8'h20, 32'h0, q, e);
    chk("unmapped error", 32'h1, {31'h0, e});
    $display("test reset done");
    // Channels 4..6 capture on their own pins, so every pin bit is exercised;
    // channel 7 compares.
    wr(PACC_OFS_CFG, 32'h0000_0008);
    timerCount <= 16'h1234;
    chanPin <= 3'h7;
    repeat (6) @(posedge clk);
    chanPin <= 3'h0;
    rd_chk("ch4 capture", PACC_OFS_VAL4, 32'h0000_1234);
    rd_chk("ch5 capture", PACC_OFS_VAL5, 32'h0000_1234);
    rd_chk("ch6 capture", PACC_OFS_VAL6, 32'h0000_1234);
    wr(PACC_OFS_VAL4, 32'h0000_BEEF);
    rd_chk("ch4 write in capture", PACC_OFS_VAL4, 32'h0000_1234);
    wr(PACC_OFS_VAL7, 32'h0000_0040);
    rd_chk("ch7 write in compare", PACC_OFS_VAL7, 32'h0000_0040);
    timerCount <= 16'h0040;
    repeat (2) @(posedge clk);
    chk("compare match", 32'h8, {28'h0, compareMatch});
    $display("test channels done");
    // Event counting with the timer off, on each edge polarity.
    wr(PACC_OFS_CFG, 32'h0);
    for (int k = 0; k < 2; k++) begin
      wr(PACC_OFS_CTRL, 32'(8'h41 | (k << 4)));
      wr(PACC_OFS_COUNT, 32'h0);
      wr(PACC_OFS_FLAGS, 32'h3);
      src.pulses(3);
      repeat (6) @(posedge clk);
      rd_chk("event count", PACC_OFS_COUNT, 32'h3);
      rd_chk("input flag", PACC_OFS_FLAGS, 32'h1);
      chk("input irq", 32'h1, {31'h0, inputIrq});
    end
    wr(PACC_OFS_FLAGS, 32'h1);
    rd_chk("input flag clear", PACC_OFS_FLAGS, 32'h0);
    chk("input irq clear", 32'h0, {31'h0, inputIrq});
    wr(PACC_OFS_CTRL, 32'h0);
    src.pulses(2);
    repeat (6) @(posedge clk);
    rd_chk("count held", PACC_OFS_COUNT, 32'h3);
    $display("test event done");
    // Rollover, overflow request, write-one clear and fast clear.
    wr(PACC_OFS_CTRL, 32'h52);
    wr(PACC_OFS_COUNT, 32'h0000_FFFF);
    src.pulses(1);
    repeat (6) @(posedge clk);
    rd_chk("rollover count", PACC_OFS_COUNT, 32'h0);
    rd_chk("overflow flag", PACC_OFS_FLAGS, 32'h3);
    chk("overflow irq", 32'h1, {31'h0, overflowIrq});
    chk("input irq masked", 32'h0, {31'h0, inputIrq});
    wr(PACC_OFS_FLAGS, 32'h2);
    rd_chk("overflow clear", PACC_OFS_FLAGS, 32'h1);
    wr(PACC_OFS_CFG, 32'h20);
    rd_chk("count read", PACC_OFS_COUNT, 32'h0);
    rd_chk("fast clear", PACC_OFS_FLAGS, 32'h0);
    $display("test overflow done");
    // Gated accumulation on each active level, then with the timer off.
    for (int k = 0; k < 2; k++) begin
      wr(PACC_OFS_CFG, 32'h10);
      wr(PACC_OFS_CTRL, 32'(8'h60 | (k << 4)));
      wr(PACC_OFS_COUNT, 32'h0);
      src.level(k[0]);
      wr(PACC_OFS_FLAGS, 32'h3);
      tick(1'b1, 2);
      src.level(!k[0]);
      tick(1'b1, 5);
      src.level(k[0]);
      rd_chk("gated count", PACC_OFS_COUNT, 32'h5);
      rd_chk("gate trailing flag", PACC_OFS_FLAGS, 32'h1);
    end
    wr(PACC_OFS_CFG, 32'h0);
    wr(PACC_OFS_COUNT, 32'h0);
    src.level(1'b0);
    tick(1'b1, 4);
    src.level(1'b1);
    rd_chk("gated timer off", PACC_OFS_COUNT, 32'h0);
    src.level(1'b0);
    $display("test gated done");
    // Counter clock selection, switched case after case with no settling gap.
    wr(PACC_OFS_CFG, 32'h10);
    for (int i = 0; i < 5; i++) begin
      wr(PACC_OFS_CTRL, {24'h0, ctlTab[i]});
      wr(PACC_OFS_COUNT, {16'h0, stTab[i]});
      c0 = ctN;
      src.pulses(pTab[i]);
      tick(1'b0, 3);
      repeat (4) @(posedge clk);
      chk("counter ticks", 32'(expTab[i]), 32'(ctN - c0));
    end
    $display("test clock select done");
    wrap_up();
  end
endmodule : tb_top
